// >>> bbc_top.sv
/*
 * Backlight bank configuration registers behind an I2C-compatible
 * port, with held low brightness byte and an 11-bit ramp.
 * Assumes open-drain SCL/SDA from outside, 20 MHz ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module bbc_top #(
   parameter logic [6:0] BUS_ADDR = bbc_pkg::DEV_ADDR,
   parameter int RAMP_STEP_CYCLES = bbc_pkg::RAMP_STEP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Serial host port
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Reset sources
   input wire logic hardware_enable_pin,
   input wire logic soft_reset,
   // Sink and boost setup
   output logic [2:0] sink_group_b,
   output logic [2:0] sink_feedback_en,
   output logic [5:0] overvoltage_threshold,
   output logic boost_freq_1mhz,
   // PWM input setup
   output logic pwm_zero_detect_en,
   output logic pwm_active_high,
   output logic pwm_group_a_en,
   output logic pwm_group_b_en,
   // Groups and brightness
   output logic group_a_en,
   output logic group_b_en,
   output logic [10:0] group_a_brightness,
   output logic group_a_ramping,
   output logic [11:0] ramp_time_us,
   output logic mapping_exponential,
   output logic [15:0] full_scale_ua
);
   import bbc_pkg::*;
   logic [2:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
   logic scl_rise, scl_fall, bus_start, bus_stop, clr;
   bbc_state_t st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, ptr_r;
   logic rw_r;
   logic wr_stb;
   logic [7:0] sink_r, fb_r, boost_r, pwm_r, low_r, high_r, grp_r;
   logic [10:0] target_r;
   bbc_ramp_if rif ();

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Order is {enable pin, scl, sda}; enable starts low so reset holds
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 3'h3;
         s2_r <= 3'h3;
         s3_r <= 3'h3;
         filt_r <= 3'h3;
      end else begin
         s1_r <= {hardware_enable_pin, scl_i, sda_i};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end
   assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
   assign scl_rise = filt_nxt[1] & ~filt_r[1];
   assign scl_fall = ~filt_nxt[1] & filt_r[1];
   assign bus_start = filt_r[1] & filt_nxt[1] & filt_r[0] & ~filt_nxt[0];
   assign bus_stop = filt_r[1] & filt_nxt[1] & ~filt_r[0] & filt_nxt[0];
   assign clr = ~filt_r[2] | soft_reset;

   // ****************************************
   // Serial port engine
   // ****************************************
   function automatic logic [7:0] rd_mux(input logic [7:0] a,
      input logic [7:0] s, f, b, p, l, h, g);
      case (a)
         OFF_SINK_GROUP: rd_mux = s;
         OFF_SINK_FB: rd_mux = f;
         OFF_BOOST: rd_mux = b;
         OFF_PWM_CFG: rd_mux = p;
         OFF_BRT_LOW: rd_mux = l;
         OFF_BRT_HIGH: rd_mux = h;
         OFF_GROUP_EN: rd_mux = g;
         default: rd_mux = UNMAPPED_READ;
      endcase
   endfunction

   assign wr_stb = scl_fall && st_r == BBC_WR && cnt_r == 4'h8;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= BBC_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
      end else if (clr || bus_stop) begin
         st_r <= BBC_IDLE;
         cnt_r <= 4'h0;
      end else if (bus_start) begin
         st_r <= BBC_ADDR;
         cnt_r <= 4'h0;
      end else if (scl_rise) begin
         case (st_r)
            BBC_ADDR, BBC_PTR, BBC_WR: begin
               sh_r <= {sh_r[6:0], filt_nxt[0]};
               cnt_r <= cnt_r + 4'h1;
            end
            BBC_RD: begin
               cnt_r <= cnt_r + 4'h1;
            end
            BBC_RACK: begin
               // Master NACK ends the read
               if (filt_nxt[0]) begin
                  st_r <= BBC_IDLE;
               end
            end
            default: begin
               cnt_r <= cnt_r;
            end
         endcase
      end else if (scl_fall) begin
         case (st_r)
            BBC_ADDR: begin
               if (cnt_r == 4'h8) begin
                  st_r <= (sh_r[7:1] == BUS_ADDR) ? BBC_ACK_A : BBC_IDLE;
                  rw_r <= sh_r[0];
               end
            end
            BBC_ACK_A, BBC_RACK: begin
               cnt_r <= 4'h0;
               if (rw_r) begin
                  st_r <= BBC_RD;
                  sh_r <= rd_mux(ptr_r, sink_r, fb_r, boost_r, pwm_r,
                     low_r, high_r, grp_r);
                  ptr_r <= ptr_r + 8'h01;
               end else begin
                  st_r <= BBC_PTR;
               end
            end
            BBC_PTR: begin
               if (cnt_r == 4'h8) begin
                  ptr_r <= sh_r;
                  st_r <= BBC_ACK_P;
               end
            end
            BBC_ACK_P, BBC_ACK_W: begin
               st_r <= BBC_WR;
               cnt_r <= 4'h0;
            end
            BBC_WR: begin
               if (cnt_r == 4'h8) begin
                  ptr_r <= ptr_r + 8'h01;
                  st_r <= BBC_ACK_W;
               end
            end
            BBC_RD: begin
               if (cnt_r == 4'h8) begin
                  st_r <= BBC_RACK;
               end else begin
                  sh_r <= {sh_r[6:0], 1'b0};
               end
            end
            default: begin
               st_r <= BBC_IDLE;
            end
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = (st_r == BBC_ACK_A) || (st_r == BBC_ACK_P) ||
      (st_r == BBC_ACK_W) || (st_r == BBC_RD && !sh_r[7]);

   // ****************************************
   // Register file
   // ****************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sink_r <= REG_RESET;
         fb_r <= REG_RESET;
         boost_r <= REG_RESET;
         pwm_r <= REG_RESET;
         low_r <= REG_RESET;
         high_r <= REG_RESET;
         grp_r <= REG_RESET;
      end else if (clr) begin
         sink_r <= REG_RESET;
         fb_r <= REG_RESET;
         boost_r <= REG_RESET;
         pwm_r <= REG_RESET;
         low_r <= REG_RESET;
         high_r <= REG_RESET;
         grp_r <= REG_RESET;
      end else if (wr_stb) begin
         case (ptr_r)
            OFF_SINK_GROUP: sink_r <= sh_r;
            OFF_SINK_FB: fb_r <= sh_r;
            OFF_BOOST: boost_r <= sh_r;
            OFF_PWM_CFG: pwm_r <= sh_r;
            OFF_BRT_LOW: low_r <= sh_r;
            OFF_BRT_HIGH: high_r <= sh_r;
            OFF_GROUP_EN: grp_r <= sh_r;
            default: grp_r <= grp_r;
         endcase
      end
   end

   // Held low byte joins only when the high byte lands
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         target_r <= 11'h000;
      end else if (clr) begin
         target_r <= 11'h000;
      end else if (wr_stb && ptr_r == OFF_BRT_HIGH) begin
         target_r <= {sh_r, low_r[BRT_LOW_W-1:0]};
      end
   end

   assign rif.target = target_r;
   assign rif.clr = clr;
   bbc_ramp #(.STEP_CYCLES(RAMP_STEP_CYCLES)) u_ramp (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .rif(rif)
   );

   // ****************************************
   // Decoded outputs
   // ****************************************
   assign sink_group_b = sink_r[SINK_FIELD_W-1:0];
   assign sink_feedback_en = fb_r[SINK_FIELD_W-1:0];
   assign overvoltage_threshold =
      bbc_ovp_volts(boost_r[BOOST_OVP_LSB +: 2]);
   assign boost_freq_1mhz = boost_r[BOOST_FREQ_BIT];
   assign pwm_zero_detect_en = pwm_r[PWM_ZERO_BIT];
   assign pwm_active_high = pwm_r[PWM_POL_BIT];
   assign pwm_group_a_en = pwm_r[PWM_A_BIT];
   assign pwm_group_b_en = pwm_r[PWM_B_BIT];
   assign group_a_en = grp_r[GRP_A_BIT];
   assign group_b_en = grp_r[GRP_B_BIT];
   assign group_a_brightness = rif.level;
   assign group_a_ramping = ~rif.at_target;
   assign ramp_time_us = RAMP_TIME_US;
   assign mapping_exponential = MAP_EXPONENTIAL;
   assign full_scale_ua = FULL_SCALE_UA;

   // ****************************************
   // Checks
   // ****************************************
   property p_sink_group;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb && ptr_r == OFF_SINK_GROUP && sh_r == 8'h04) |=>
         sink_group_b == 3'h4;
   endproperty
   a_sink_group: assert property (p_sink_group)
      else $error("sinks one and two not in group A");
   property p_feedback;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb && ptr_r == OFF_SINK_FB && sh_r == 8'h03) |=>
         sink_feedback_en == 3'h3;
   endproperty
   a_feedback: assert property (p_feedback)
      else $error("feedback enables wrong");
   property p_boost;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb && ptr_r == OFF_BOOST) |=>
         ($past(sh_r) == 8'h04 |-> overvoltage_threshold == OVP_32V) and
         ($past(sh_r) == 8'h02 |-> overvoltage_threshold == OVP_24V) and
         (!boost_freq_1mhz || $past(sh_r[0]));
   endproperty
   a_boost: assert property (p_boost)
      else $error("boost setting wrong");
   property p_pwm;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb && ptr_r == OFF_PWM_CFG && sh_r == 8'h0d) |=>
         pwm_zero_detect_en && pwm_active_high && pwm_group_a_en &&
         !pwm_group_b_en;
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("pwm setup wrong");
   property p_group_en;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb && ptr_r == OFF_GROUP_EN && sh_r == 8'h01) |=>
         group_a_en && !group_b_en;
   endproperty
   a_group_en: assert property (p_group_en)
      else $error("group A not enabled");
   property p_low_held;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && !(wr_stb && ptr_r == OFF_BRT_HIGH)) |=> $stable(target_r);
   endproperty
   a_low_held: assert property (p_low_held)
      else $error("brightness target moved without high write");
   property p_defaults;
      @(posedge ref_clk) disable iff (!nrst)
      clr |=> ramp_time_us == 12'h800 && mapping_exponential &&
         full_scale_ua == 16'h4ee8 && group_a_brightness == 11'h000;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults wrong after reset");
   property p_ovp_reset;
      @(posedge ref_clk) disable iff (!nrst)
      clr |=> overvoltage_threshold == OVP_16V;
   endproperty
   a_ovp_reset: assert property (p_ovp_reset)
      else $error("threshold not back at 16 V");
   property p_readback;
      @(posedge ref_clk) disable iff (!nrst)
      (!clr && wr_stb) ##1 !clr |->
         rd_mux($past(ptr_r), sink_r, fb_r, boost_r, pwm_r, low_r, high_r,
            grp_r) == (($past(ptr_r) == OFF_SINK_GROUP ||
            $past(ptr_r) == OFF_SINK_FB || $past(ptr_r) == OFF_BOOST ||
            $past(ptr_r) == OFF_PWM_CFG || $past(ptr_r) == OFF_BRT_LOW ||
            $past(ptr_r) == OFF_BRT_HIGH || $past(ptr_r) == OFF_GROUP_EN) ?
            $past(sh_r) : UNMAPPED_READ);
   endproperty
   a_readback: assert property (p_readback)
      else $error("register readback mismatch");
   c_high_write: cover property (@(posedge ref_clk) disable iff (!nrst)
      wr_stb && ptr_r == OFF_BRT_HIGH);
   c_read: cover property (@(posedge ref_clk) disable iff (!nrst)
      st_r == BBC_RD ##1 st_r == BBC_RACK);
   c_pin_reset: cover property (@(posedge ref_clk) disable iff (!nrst)
      !filt_r[2] ##1 filt_r[2]);
endmodule
`default_nettype wire

// >>> bbc_pkg.sv
/*
 * Constants, register map, field layout and state encoding for the
 * backlight bank configuration block.
 * Assumes a 20 MHz reference clock and an I2C-compatible host port.
 */
`default_nettype none
package bbc_pkg;
   // ****************************************
   // Register offsets and reset values
   // ****************************************
   localparam logic [7:0] OFF_SINK_GROUP = 8'h10;
   localparam logic [7:0] OFF_SINK_FB = 8'h19;
   localparam logic [7:0] OFF_BOOST = 8'h1a;
   localparam logic [7:0] OFF_PWM_CFG = 8'h1c;
   localparam logic [7:0] OFF_BRT_LOW = 8'h20;
   localparam logic [7:0] OFF_BRT_HIGH = 8'h21;
   localparam logic [7:0] OFF_GROUP_EN = 8'h24;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int SINK_FIELD_W = 3;
   localparam int BOOST_FREQ_BIT = 0;
   localparam int BOOST_OVP_LSB = 1;
   localparam int PWM_A_BIT = 0;
   localparam int PWM_B_BIT = 1;
   localparam int PWM_POL_BIT = 2;
   localparam int PWM_ZERO_BIT = 3;
   localparam int GRP_A_BIT = 0;
   localparam int GRP_B_BIT = 1;
   localparam int BRT_W = 11;
   localparam int BRT_LOW_W = 3;
   // ****************************************
   // Threshold codes, defaults and timing
   // ****************************************
   localparam logic [5:0] OVP_16V = 6'h10;
   localparam logic [5:0] OVP_24V = 6'h18;
   localparam logic [5:0] OVP_32V = 6'h20;
   localparam logic [5:0] OVP_40V = 6'h28;
   localparam logic [11:0] RAMP_TIME_US = 12'h800;
   localparam logic [15:0] FULL_SCALE_UA = 16'h4ee8;
   localparam logic MAP_EXPONENTIAL = 1'b1;
   localparam int CLK_HZ = 20_000_000;
   // One 8-bit level step spans the ramp time, in 2**BRT_LOW_W counts
   localparam int RAMP_STEP_CYC =
      (int'(RAMP_TIME_US) * (CLK_HZ / 1_000_000)) / (1 << BRT_LOW_W);
   // Bus address is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h36;
   typedef enum logic [3:0] {
      BBC_IDLE = 4'h0,
      BBC_ADDR = 4'h1,
      BBC_ACK_A = 4'h2,
      BBC_PTR = 4'h3,
      BBC_ACK_P = 4'h4,
      BBC_WR = 4'h5,
      BBC_ACK_W = 4'h6,
      BBC_RD = 4'h7,
      BBC_RACK = 4'h8
   } bbc_state_t;
   function automatic logic [5:0] bbc_ovp_volts(input logic [1:0] code);
      case (code)
         2'h0: bbc_ovp_volts = OVP_16V;
         2'h1: bbc_ovp_volts = OVP_24V;
         2'h2: bbc_ovp_volts = OVP_32V;
         default: bbc_ovp_volts = OVP_40V;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> bbc_ramp_if.sv
/*
 * Carrier between the register bank and the brightness ramp.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface bbc_ramp_if;
   logic [10:0] target;
   logic [10:0] level;
   logic clr;
   logic at_target;
   modport ctrl (output target, output clr, input level, input at_target);
   modport ramp (input target, input clr, output level, output at_target);
endinterface
`default_nettype wire

// >>> bbc_ramp.sv
/*
 * Brightness ramp: walks the 11-bit level one count per step toward
 * the target. Assumes a single clock and an active-low async reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bbc_ramp #(
   parameter int STEP_CYCLES = bbc_pkg::RAMP_STEP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Ramp carrier
   bbc_ramp_if.ramp rif
);
   import bbc_pkg::*;
   logic [15:0] cnt_r;
   logic [10:0] level_r;

   // ****************************************
   // Step divider and level
   // ****************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 16'h0000;
      end else if (rif.clr || level_r == rif.target) begin
         cnt_r <= 16'h0000;
      end else if (cnt_r == 16'(STEP_CYCLES - 1)) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // Low bits fill in between host levels
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         level_r <= 11'h000;
      end else if (rif.clr) begin
         level_r <= 11'h000;
      end else if (level_r != rif.target &&
                   cnt_r == 16'(STEP_CYCLES - 1)) begin
         if (level_r < rif.target) begin
            level_r <= level_r + 11'h001;
         end else begin
            level_r <= level_r - 11'h001;
         end
      end
   end
   assign rif.level = level_r;
   assign rif.at_target = (level_r == rif.target);

   // ****************************************
   // Checks
   // ****************************************
   property p_ramp_one_count;
      @(posedge ref_clk) disable iff (!nrst)
      (!rif.clr && level_r != rif.target) |=>
         (level_r == $past(level_r) || level_r == $past(level_r) + 11'h001
          || level_r == $past(level_r) - 11'h001);
   endproperty
   a_ramp_one_count: assert property (p_ramp_one_count)
      else $error("ramp moved more than one count");
   c_ramp_done: cover property (@(posedge ref_clk) disable iff (!nrst)
      !rif.at_target ##1 rif.at_target);
endmodule
`default_nettype wire

// >>> bbc_host_model.sv
/*
 * Host controller model for the serial port of the backlight bank block.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module bbc_host_model #(
   parameter logic [6:0] ADDR = bbc_pkg::DEV_ADDR
) (
   // Clock and resolved data line
   input wire logic ref_clk,
   input wire logic sda_line,
   // Host drive
   output var logic scl,
   output var logic sda_pull,
   // Read results and port errors
   output var logic [7:0] rd_data,
   output var logic rd_valid,
   output var logic ack_miss
);
   // ****************************************
   // Bit and byte level
   // ****************************************
   // Six cycles per phase: the pin filter needs at least two
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_data = 8'h00;
      rd_valid = 1'b0;
      ack_miss = 1'b0;
   end
   task automatic hc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic put_bit(input logic b);
      hc(3);
      sda_pull = ~b;
      hc(3);
      scl = 1'b1;
      hc(6);
      scl = 1'b0;
   endtask
   task automatic get_bit(output logic b);
      hc(3);
      sda_pull = 1'b0;
      hc(3);
      scl = 1'b1;
      hc(3);
      b = sda_line;
      hc(3);
      scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(a);
      if (a !== 1'b0) begin
         ack_miss = 1'b1;
      end
   endtask
   task automatic start_cond;
      hc(3);
      sda_pull = 1'b0;
      hc(3);
      scl = 1'b1;
      hc(6);
      sda_pull = 1'b1;
      hc(6);
      scl = 1'b0;
   endtask
   task automatic stop_cond;
      hc(3);
      sda_pull = 1'b1;
      hc(3);
      scl = 1'b1;
      hc(6);
      sda_pull = 1'b0;
      hc(6);
   endtask
   // ****************************************
   // Register transfers
   // ****************************************
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      start_cond;
      send_byte({ADDR, 1'b0});
      send_byte(a);
      send_byte(d);
      stop_cond;
   endtask
   // Low byte first, high byte next through pointer increment
   task automatic write_bright(input logic [7:0] lo, input logic [7:0] hi);
      start_cond;
      send_byte({ADDR, 1'b0});
      send_byte(bbc_pkg::OFF_BRT_LOW);
      send_byte(lo);
      send_byte(hi);
      stop_cond;
   endtask
   task automatic read_reg(input logic [7:0] a);
      logic [7:0] d;
      start_cond;
      send_byte({ADDR, 1'b0});
      send_byte(a);
      start_cond;
      send_byte({ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(1'b1);
      stop_cond;
      rd_data = d;
      rd_valid = 1'b1;
      hc(1);
      rd_valid = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> bbc_top_test.sv
/*
 * Self-checking bench for the backlight bank configuration block.
 * Assumes bbc_host_model drives the serial port as bus master.
 */
`timescale 1ns/1ps
`default_nettype none
module bbc_top_test;
   import bbc_pkg::*;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic ref_clk, nrst, hw_en, soft_rst;
   logic scl, host_pull, sda_o, sda_oe, rd_valid, ack_miss, boost_freq_1mhz;
   logic pwm_zero_detect_en, pwm_active_high, pwm_group_a_en, pwm_group_b_en;
   logic group_a_en, group_b_en, group_a_ramping, mapping_exponential;
   logic mon_on = 1'b0;
   logic [2:0] sink_group_b, sink_feedback_en;
   logic [5:0] overvoltage_threshold;
   logic [7:0] rd_data, rd_exp;
   logic [10:0] group_a_brightness, last_lvl = 11'h000;
   logic [11:0] ramp_time_us;
   logic [15:0] full_scale_ua;
   wire sda_line;
   assign sda_line = ~(host_pull | (sda_oe & ~sda_o));
   int n_fail = 0, total_checks = 0, n_steps = 0;
   logic [7:0] exp_q[$];
   logic [7:0] rvs[7];
   logic [7:0] offs[7] = '{8'h10, 8'h19, 8'h1a, 8'h1c, 8'h24, 8'h20, 8'h21};
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   bbc_top #(.RAMP_STEP_CYCLES(4)) DUT (.ref_clk(ref_clk), .nrst(nrst),
      .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .hardware_enable_pin(hw_en), .soft_reset(soft_rst),
      .sink_group_b(sink_group_b), .sink_feedback_en(sink_feedback_en),
      .overvoltage_threshold(overvoltage_threshold),
      .boost_freq_1mhz(boost_freq_1mhz),
      .pwm_zero_detect_en(pwm_zero_detect_en),
      .pwm_active_high(pwm_active_high), .pwm_group_a_en(pwm_group_a_en),
      .pwm_group_b_en(pwm_group_b_en), .group_a_en(group_a_en),
      .group_b_en(group_b_en), .group_a_brightness(group_a_brightness),
      .group_a_ramping(group_a_ramping), .ramp_time_us(ramp_time_us),
      .mapping_exponential(mapping_exponential),
      .full_scale_ua(full_scale_ua));
   bbc_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
      .sda_pull(host_pull), .rd_data(rd_data), .rd_valid(rd_valid),
      .ack_miss(ack_miss));
   // ****************************************
   // Compare, report and wait tasks
   // ****************************************
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // A full-scale ramp takes 2047 steps; the spare edge lets the
   // step watcher count the final step before anyone reads it
   task automatic wait_idle;
      int k;
      k = 0;
      while (group_a_ramping !== 1'b0 && k < 10000) begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 10000) begin
         n_fail++;
         $display("Error %0t: ramp never settled", $time);
         tally_and_finish;
      end else begin
         @(negedge ref_clk);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.read_reg(a);
   endtask
   // ****************************************
   // Result watchers
   // ****************************************
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_val(16'(rd_data), 16'hffff, "unexpected read");
         end else begin
            rd_exp = exp_q.pop_front();
            check_val(16'(rd_data), 16'(rd_exp), "read");
         end
      end
   end
   // Level may only move one count per step
   always @(posedge ref_clk) begin
      if (mon_on && group_a_brightness !== last_lvl) begin
         n_steps++;
         check_val(16'(group_a_brightness > last_lvl ?
            group_a_brightness - last_lvl : last_lvl - group_a_brightness),
            16'h0001, "ramp step");
      end
      last_lvl = group_a_brightness;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      hw_en = 1'b1;
      soft_rst = 1'b0;
      void'($urandom(32'he6db));
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      host.hc(8);
      check_val(16'(overvoltage_threshold), 16'h0010, "ovp");
      check_val(16'(ramp_time_us), 16'h0800, "ramp time");
      check_val(full_scale_ua, 16'h4ee8, "full scale");
      check_val(16'(mapping_exponential), 16'h0001, "mapping");
      for (int i = 0; i < 7; i++) begin
         rd(offs[i], 8'h00);
      end
      host.write_reg(8'h10, 8'h04);
      host.write_reg(8'h19, 8'h03);
      host.write_reg(8'h1a, 8'h04);
      host.write_reg(8'h1c, 8'h0d);
      host.write_reg(8'h24, 8'h01);
      check_val(16'(sink_group_b), 16'h0004, "sinks");
      check_val(16'(sink_feedback_en), 16'h0003, "feedback");
      check_val(16'(overvoltage_threshold), 16'h0020, "ovp");
      check_val(16'(boost_freq_1mhz), 16'h0000, "freq");
      check_val(16'({pwm_zero_detect_en, pwm_active_high, pwm_group_b_en,
         pwm_group_a_en}), 16'h000d, "pwm");
      check_val(16'({group_b_en, group_a_en}), 16'h0001,
         "groups");
      rd(8'h1c, 8'h0d);
      host.write_reg(8'h1a, 8'h02);
      check_val(16'(overvoltage_threshold), 16'h0018, "ovp");
      check_val(16'(boost_freq_1mhz), 16'h0000, "freq");
      // Low byte alone must not move the level
      mon_on = 1'b1;
      host.write_reg(8'h20, 8'h05);
      host.hc(40);
      check_val(16'(group_a_brightness), 16'h0000, "held low");
      check_val(16'(n_steps), 16'h0000, "held steps");
      host.write_reg(8'h21, 8'h02);
      wait_idle;
      check_val(16'(group_a_brightness), 16'h0015, "level");
      n_steps = 0;
      host.write_reg(8'h21, 8'h03);
      wait_idle;
      check_val(16'(group_a_brightness), 16'h001d, "level");
      check_val(16'(n_steps), 16'h0008, "steps");
      host.write_bright(8'h02, 8'h01);
      wait_idle;
      check_val(16'(group_a_brightness), 16'h000a, "level");
      // Random bytes through every register, plus an unmapped place
      for (int i = 0; i < 7; i++) begin
         rvs[i] = 8'($urandom);
         host.write_reg(offs[i], rvs[i]);
         rd(offs[i], rvs[i]);
      end
      host.write_reg(8'h11, 8'h5a);
      rd(8'h11, 8'h00);
      wait_idle;
      // Every decoded field must follow the random bytes
      check_val(16'(sink_group_b), 16'(rvs[0][2:0]), "sinks");
      check_val(16'(sink_feedback_en), 16'(rvs[1][2:0]), "fb");
      check_val(16'(boost_freq_1mhz), 16'(rvs[2][0]), "freq");
      check_val(16'(overvoltage_threshold), 16'(16 + 8 * rvs[2][2:1]),
         "rnd ovp");
      check_val(16'({pwm_zero_detect_en, pwm_active_high, pwm_group_b_en,
         pwm_group_a_en}), 16'(rvs[3][3:0]), "rnd pwm");
      check_val(16'({group_b_en, group_a_en}), 16'(rvs[4][1:0]),
         "rnd groups");
      check_val(16'(group_a_brightness), 16'({rvs[6], rvs[5][2:0]}),
         "rnd level");
      mon_on = 1'b0;
      host.write_reg(8'h1a, 8'h04);
      soft_rst = 1'b1;
      host.hc(3);
      soft_rst = 1'b0;
      host.hc(3);
      check_val(16'(overvoltage_threshold), 16'h0010, "soft ovp");
      check_val(16'(group_a_brightness), 16'h0000, "soft level");
      rd(8'h1a, 8'h00);
      host.write_reg(8'h1a, 8'h06);
      check_val(16'(overvoltage_threshold), 16'h0028, "ovp");
      hw_en = 1'b0;
      host.hc(6);
      hw_en = 1'b1;
      host.hc(8);
      check_val(16'(overvoltage_threshold), 16'h0010, "pin ovp");
      check_val(16'(ack_miss), 16'h0000, "acks");
      check_val(16'(exp_q.size()), 16'h0000, "reads left");
      tally_and_finish;
   end
endmodule
`default_nettype wire
